// >>> hdl/copper_phy_control_regs.v
// Purpose : Control register bank of a copper Ethernet transceiver
// Assumes : Inputs synchronous to sys_clk; one-cycle bus strobes
// Notes   : soft_reset is a one-cycle software reset request
`timescale 1ns/10ps
`include "copper_phy_control_regs.vh"

// Contract
// - Each of four low polarity bits inverts transmit polarity of one pair.
// - 16-bit receive error count clears on hard reset, saturates at all ones.
// - Count increments once per cycle with a false-carrier or symbol-error event.
// - Page number in low byte; clears on hard reset, kept on soft reset.
// - Page register reachable on any page; upper byte reads zero.
// - Restart-negotiation bit starts negotiation, self clears, resets to zero.
// - Bits 15 and 12 pick transmitter class A when one, B when zero.
// - Gigabit-disable bit suppresses gigabit advertisement regardless of 9.9/9.8.
// - Gigabit-disable and reverse bits apply only after listed trigger events.
// - Gigabit-disable follows strap at hard reset and on later strap edges.
// - Reverse-negotiation bit follows its strap at hard reset and on edges.
// - Test field 3:2: normal, 112 ns sequence on 10b, 16 ns on 11b.
// - Bit 1 forces negative 10 Mb receive polarity only.
module copper_phy_control_regs (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        soft_reset,
  // Register port
  input  wire [4:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [15:0] reg_rdata,
  // Receive path events
  input  wire        false_carrier_event,
  input  wire        symbol_error_event,
  // Straps and apply triggers
  input  wire        gigabit_disable_strap,
  input  wire        reverse_negotiation_strap,
  input  wire        power_up_event,
  input  wire        link_down_event,
  input  wire        gig_adv_bits,
  // Controls to the transceiver
  output reg  [3:0]  tx_polarity_invert,
  output reg  [7:0]  page_number,
  output reg         restart_negotiation,
  output reg         advertise_gigabit,
  output reg         reverse_negotiation,
  output reg         gig_tx_class_a,
  output reg         fast_tx_class_a,
  output reg         test_seq_112ns,
  output reg         test_seq_16ns,
  output reg         rx10_force_negative,
  // Interrupt
  output reg         irq
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  reg  [15:0] tx_polarity;
  reg  [15:0] rx_err_count;
  reg  [15:0] neg_options;
  reg  [15:0] copper_ctrl2;
  reg  [2:0]  irq_status;
  reg  [2:0]  irq_mask;
  reg         gig_dis_applied;
  reg         rev_applied;
  reg         strap_gd_q;
  reg         strap_rv_q;
  reg         strap_seen;
  reg         strap_seen_q;
  reg         restart_pending;
  reg  [15:0] next_rdata;
  reg  [15:0] next_ctrl2;
  reg  [15:0] next_neg_options;
  reg  [2:0]  next_irq_status;
  genvar      pair;

  // ---------------------------------------------------------------
  // Write decode and event sources
  // ---------------------------------------------------------------
  wire        wr_pol;
  wire        wr_page;
  wire        wr_neg;
  wire        wr_ctrl2;
  wire        wr_istat;
  wire        wr_imask;
  wire        rx_err;
  wire        at_max;
  wire        restart_issue;
  wire        strap_gd_edge;
  wire        strap_rv_edge;
  wire        first_apply;
  wire        apply_now;
  wire [2:0]  events;
  wire [2:0]  istat_clear;

  assign wr_pol        = reg_write && (reg_addr == `OFF_TX_POLARITY);
  assign wr_page       = reg_write && (reg_addr == `OFF_PAGE_SELECT);
  assign wr_neg        = reg_write && (reg_addr == `OFF_NEG_OPTIONS);
  assign wr_ctrl2      = reg_write && (reg_addr == `OFF_COPPER_CTRL2);
  assign wr_istat      = reg_write && (reg_addr == `OFF_IRQ_STATUS);
  assign wr_imask      = reg_write && (reg_addr == `OFF_IRQ_MASK);
  assign rx_err        = false_carrier_event | symbol_error_event;
  assign at_max        = (rx_err_count == `MAX_RX_ERR_COUNT);
  assign restart_issue = wr_neg && reg_wdata[`BIT_RESTART_NEG];
  assign strap_gd_edge = (gigabit_disable_strap != strap_gd_q);
  assign strap_rv_edge = (reverse_negotiation_strap != strap_rv_q);
  assign first_apply   = strap_seen && !strap_seen_q;
  assign apply_now     = soft_reset | restart_issue | power_up_event
                       | link_down_event;
  assign events        = {rx_err, rx_err & at_max, restart_issue};
  assign istat_clear   = wr_istat ? reg_wdata[2:0] : 3'h0;

  // ---------------------------------------------------------------
  // Registers kept over software reset
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      tx_polarity <= `RST_TX_POLARITY;
    end else if (wr_pol) begin
      tx_polarity <= reg_wdata;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      page_number <= `RST_PAGE;
    end else if (wr_page) begin
      page_number <= reg_wdata[7:0];
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      irq_mask <= `RST_IRQ;
    end else if (wr_imask) begin
      irq_mask <= reg_wdata[2:0];
    end
  end

  // ---------------------------------------------------------------
  // Receive error counter
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      rx_err_count <= `RST_RX_ERR_COUNT;
    end else if (rx_err && !at_max) begin
      rx_err_count <= rx_err_count + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Strap tracking and second control register
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      strap_seen   <= `RST_BIT;
      strap_seen_q <= `RST_BIT;
    end else begin
      strap_seen   <= 1'b1;
      strap_seen_q <= strap_seen;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      strap_gd_q <= `RST_BIT;
      strap_rv_q <= `RST_BIT;
    end else begin
      strap_gd_q <= gigabit_disable_strap;
      strap_rv_q <= reverse_negotiation_strap;
    end
  end

  always @* begin
    next_ctrl2 = copper_ctrl2;
    if (wr_ctrl2) begin
      next_ctrl2 = reg_wdata & `CTRL2_RW_MASK;
    end
    if (!strap_seen) begin
      next_ctrl2[`BIT_GIGABIT_DISABLE] = gigabit_disable_strap;
      next_ctrl2[`BIT_REVERSE_NEG]     = reverse_negotiation_strap;
    end else begin
      if (strap_gd_edge) begin
        next_ctrl2[`BIT_GIGABIT_DISABLE] = gigabit_disable_strap;
      end
      if (strap_rv_edge) begin
        next_ctrl2[`BIT_REVERSE_NEG] = reverse_negotiation_strap;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      copper_ctrl2 <= `RST_COPPER_CTRL2;
    end else begin
      copper_ctrl2 <= next_ctrl2;
    end
  end

  // ---------------------------------------------------------------
  // Negotiation options
  // ---------------------------------------------------------------
  always @* begin
    next_neg_options = neg_options;
    if (soft_reset) begin
      next_neg_options = neg_options & `NEG_OPT_RW_MASK;
    end else if (wr_neg) begin
      next_neg_options = reg_wdata & `NEG_OPT_WR_MASK;
    end else if (restart_pending) begin
      next_neg_options[`BIT_RESTART_NEG] = 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      neg_options <= `RST_NEG_OPTIONS;
    end else begin
      neg_options <= next_neg_options;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      restart_pending <= `RST_BIT;
    end else begin
      restart_pending <= restart_issue;
    end
  end

  // ---------------------------------------------------------------
  // Deferred settings
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      gig_dis_applied <= `RST_BIT;
      rev_applied     <= `RST_BIT;
    end else if (apply_now || first_apply) begin
      gig_dis_applied <= copper_ctrl2[`BIT_GIGABIT_DISABLE];
      rev_applied     <= copper_ctrl2[`BIT_REVERSE_NEG];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------
  always @* begin
    next_irq_status = (irq_status & ~istat_clear) | events;
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      irq_status <= `RST_IRQ;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      irq <= `RST_BIT;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  generate
    for (pair = 0; pair < 4; pair = pair + 1) begin : g_pair
      always @(posedge sys_clk) begin
        if (reset) begin
          tx_polarity_invert[pair] <= `RST_BIT;
        end else begin
          tx_polarity_invert[pair] <= tx_polarity[pair];
        end
      end
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (reset) begin
      restart_negotiation <= `RST_BIT;
    end else begin
      restart_negotiation <= restart_issue;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      advertise_gigabit <= `RST_BIT;
    end else begin
      advertise_gigabit <= gig_adv_bits & ~gig_dis_applied;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      reverse_negotiation <= `RST_BIT;
    end else begin
      reverse_negotiation <= rev_applied;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      gig_tx_class_a <= `RST_BIT;
    end else begin
      gig_tx_class_a <= copper_ctrl2[`BIT_GIG_TX_CLASS];
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      fast_tx_class_a <= `RST_BIT;
    end else begin
      fast_tx_class_a <= copper_ctrl2[`BIT_FAST_TX_CLASS];
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      test_seq_112ns <= `RST_BIT;
    end else begin
      test_seq_112ns <= (copper_ctrl2[3:2] == `TEST_SEQ_112NS);
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      test_seq_16ns <= `RST_BIT;
    end else begin
      test_seq_16ns <= (copper_ctrl2[3:2] == `TEST_SEQ_16NS);
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      rx10_force_negative <= `RST_BIT;
    end else begin
      rx10_force_negative <= copper_ctrl2[`BIT_RX10_POL_FORCE];
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always @* begin
    case (reg_addr)
      `OFF_TX_POLARITY:  next_rdata = tx_polarity;
      `OFF_RX_ERR_COUNT: next_rdata = rx_err_count;
      `OFF_PAGE_SELECT:  next_rdata = {8'h00, page_number};
      `OFF_NEG_OPTIONS:  next_rdata = neg_options;
      `OFF_COPPER_CTRL2: next_rdata = copper_ctrl2;
      `OFF_IRQ_STATUS:   next_rdata = {13'h0000, irq_status};
      `OFF_IRQ_MASK:     next_rdata = {13'h0000, irq_mask};
      default:           next_rdata = `RST_RDATA;
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= `RST_RDATA;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `RST_RDATA;
    end
  end

endmodule // copper_phy_control_regs

// >>> hdl/copper_phy_control_regs.vh
// Purpose : Constants for the copper transceiver control register bank
// Assumes : 16-bit registers addressed by 5-bit register number
// Notes   : Offsets are register numbers on the management port
`ifndef COPPER_PHY_CONTROL_REGS_VH
`define COPPER_PHY_CONTROL_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFF_TX_POLARITY     5'h14
`define OFF_RX_ERR_COUNT    5'h15
`define OFF_PAGE_SELECT     5'h16
`define OFF_NEG_OPTIONS     5'h19
`define OFF_COPPER_CTRL2    5'h1A
`define OFF_IRQ_STATUS      5'h1B
`define OFF_IRQ_MASK        5'h1C

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_RESTART_NEG     10
`define BIT_GIG_TX_CLASS    15
`define BIT_GIGABIT_DISABLE 14
`define BIT_REVERSE_NEG     13
`define BIT_FAST_TX_CLASS   12
`define BIT_TEST_HI         3
`define BIT_TEST_LO         2
`define BIT_RX10_POL_FORCE  1
`define BIT_EV_RESTART      0
`define BIT_EV_SATURATED    1
`define BIT_EV_RX_ERROR     2

// ---------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------
`define RST_TX_POLARITY     16'h0000
`define RST_RX_ERR_COUNT    16'h0000
`define MAX_RX_ERR_COUNT    16'hFFFF
`define RST_PAGE            8'h00
`define RST_NEG_OPTIONS     16'h0000
`define RST_IRQ             3'h0
`define CTRL2_RW_MASK       16'hF00E
`define NEG_OPT_RW_MASK     16'h0044
`define NEG_OPT_WR_MASK     16'h0444
`define RST_COPPER_CTRL2    16'h0000
`define RST_RDATA           16'h0000
`define RST_BIT             1'h0

// ---------------------------------------------------------------
// Test sequence codes
// ---------------------------------------------------------------
`define TEST_SEQ_112NS      2'h2
`define TEST_SEQ_16NS       2'h3

`endif

// >>> sim/copper_phy_control_regs_props.sv
// Purpose: Port assertions for the control register bank
// Assumes: One-cycle strobes; outputs settle within two edges
// Notes  : Bound to every bank instance
`timescale 1ns/10ps
`include "copper_phy_control_regs.vh"
module copper_phy_control_regs_props (
  // Clock and bus
  input wire        sys_clk,
  input wire        reset,
  input wire [4:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_write,
  input wire        reg_read,
  input wire [15:0] reg_rdata,
  // Controls
  input wire [3:0]  tx_polarity_invert,
  input wire [7:0]  page_number,
  input wire        restart_negotiation,
  input wire        gig_tx_class_a,
  input wire        test_seq_112ns,
  input wire        rx10_force_negative
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence wr_at(logic [4:0] a);
    reg_write && reg_addr == a;
  endsequence
  sequence one_pulse;
    restart_negotiation ##1 !restart_negotiation;
  endsequence
  a_polarity_follows:
    assert property (wr_at(`OFF_TX_POLARITY) |-> ##2
      tx_polarity_invert == $past(reg_wdata[3:0], 2)) else $error("pol");
  a_page_follows:
    assert property (wr_at(`OFF_PAGE_SELECT) |-> ##2
      page_number == $past(reg_wdata[7:0], 2)) else $error("page");
  a_page_upper_zero:
    assert property (reg_read && reg_addr == `OFF_PAGE_SELECT |=>
      reg_rdata[15:8] == 8'h00) else $error("page upper");
  a_restart_pulse:
    assert property ((wr_at(`OFF_NEG_OPTIONS) ##0
      reg_wdata[`BIT_RESTART_NEG]) |=> one_pulse) else $error("restart");
  a_class_follows:
    assert property (wr_at(`OFF_COPPER_CTRL2) |-> ##2
      gig_tx_class_a == $past(reg_wdata[15], 2)) else $error("class");
  a_test_code:
    assert property (wr_at(`OFF_COPPER_CTRL2) |-> ##2 test_seq_112ns ==
      ($past(reg_wdata[3:2], 2) == `TEST_SEQ_112NS)) else $error("test");
  a_rx10_force:
    assert property (wr_at(`OFF_COPPER_CTRL2) |-> ##2
      rx10_force_negative == $past(reg_wdata[1], 2)) else $error("rx10");
  a_restart_clears:
    assert property (restart_negotiation |=> !restart_negotiation[*2])
      else $error("restart held");
endmodule // copper_phy_control_regs_props
bind copper_phy_control_regs copper_phy_control_regs_props i_props (.*);

// >>> sim/rx_error_source.sv
// Purpose: Receive path model issuing error events
// Assumes: start is a one-cycle pulse
// Notes  : Gives burst cycles with an event; some carry both kinds
`timescale 1ns/10ps
module rx_error_source (
  // Control
  input  wire        sys_clk,
  input  wire        start,
  input  wire [16:0] burst,
  // Receive path events
  output reg         false_carrier_event,
  output reg         symbol_error_event
);
  reg [16:0] left = 17'h00000;
  initial {false_carrier_event, symbol_error_event} = 2'b00;
  always @(posedge sys_clk) begin
    if (start) left <= burst;
    else if (left != 17'h00000) left <= left - 17'h00001;
    false_carrier_event <= !start && left != 17'h00000;
    symbol_error_event <= !start && left[0];
  end
endmodule // rx_error_source

// >>> sim/copper_phy_control_regs_bench.sv
// Purpose: Self-checking bench for the control register bank
// Assumes: Bus driven by non-blocking assignment after rising edges
// Notes  : Counter saturation run dominates the run time
`timescale 1ns/10ps
`include "copper_phy_control_regs.vh"
module copper_phy_control_regs_bench;
  reg sys_clk, reset, soft_reset, reg_write, reg_read, start;
  reg gigabit_disable_strap, reverse_negotiation_strap, gig_adv_bits;
  reg power_up_event, link_down_event;
  reg [4:0] reg_addr;
  reg [15:0] reg_wdata;
  reg [16:0] burst;
  wire [15:0] reg_rdata;
  wire [3:0] tx_polarity_invert;
  wire [7:0] page_number;
  wire restart_negotiation, advertise_gigabit, reverse_negotiation, irq;
  wire gig_tx_class_a, fast_tx_class_a, test_seq_112ns, test_seq_16ns;
  wire rx10_force_negative, false_carrier_event, symbol_error_event;
  integer miscompares, total_checks, i;
  copper_phy_control_regs i_copper_phy_control_regs (.*);
  rx_error_source i_rx_error_source (.*);
  task chk(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    begin
      @(posedge sys_clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk) reg_write <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
    end
  endtask
  task rd(input [4:0] a, input [15:0] exp);
    begin
      @(posedge sys_clk) {reg_read, reg_addr} <= {1'b1, a};
      @(posedge sys_clk) reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares = miscompares + 1;
    tally_and_finish;
  end
  initial begin
    {reset, soft_reset, reg_write, reg_read, start} = 5'b10000;
    {gigabit_disable_strap, reverse_negotiation_strap, gig_adv_bits} = 3'h7;
    {power_up_event, link_down_event, reg_addr} = 7'h00;
    {reg_wdata, burst} = 33'h000000000;
    {miscompares, total_checks} = 64'h0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk({advertise_gigabit, reverse_negotiation}, 16'h0001);
    rd(`OFF_COPPER_CTRL2, 16'h6000);
    rd(`OFF_TX_POLARITY, 16'h0000);
    rd(`OFF_PAGE_SELECT, 16'h0000);
    rd(5'h03, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`OFF_TX_POLARITY, 16'h0001 << i);
      chk(tx_polarity_invert, 16'h0001 << i);
      wr(`OFF_COPPER_CTRL2, 16'h1002 | (i << 2) | (i << 15));
      chk({gig_tx_class_a, fast_tx_class_a, test_seq_112ns, test_seq_16ns,
        rx10_force_negative}, {i[0], 1'b1, i == 2, i == 3, 1'b1});
    end
    chk({advertise_gigabit, reverse_negotiation}, 16'h0001);
    wr(`OFF_PAGE_SELECT, 16'hFFAB);
    chk(page_number, 16'h00AB);
    @(posedge sys_clk) soft_reset <= 1'b1;
    @(posedge sys_clk) soft_reset <= 1'b0;
    rd(`OFF_PAGE_SELECT, 16'h00AB);
    rd(`OFF_TX_POLARITY, 16'h0008);
    chk({advertise_gigabit, reverse_negotiation}, 16'h0002);
    wr(`OFF_COPPER_CTRL2, 16'h6000);
    gig_adv_bits <= 1'b0;
    wr(`OFF_COPPER_CTRL2, 16'h2000);
    chk({advertise_gigabit, reverse_negotiation}, 16'h0000);
    link_down_event <= 1'b1;
    wr(5'h03, 16'hFFFF);
    chk({advertise_gigabit, reverse_negotiation}, 16'h0001);
    {link_down_event, gigabit_disable_strap} <= 2'b00;
    reverse_negotiation_strap <= 1'b0;
    repeat (3) @(posedge sys_clk) gigabit_disable_strap <= 1'b1;
    rd(`OFF_COPPER_CTRL2, 16'h4000);
    wr(`OFF_NEG_OPTIONS, 16'h0400);
    chk({advertise_gigabit, reverse_negotiation, irq}, 16'h0000);
    rd(`OFF_NEG_OPTIONS, 16'h0000);
    wr(`OFF_IRQ_MASK, 16'h0001);
    chk(irq, 16'h0001);
    wr(`OFF_IRQ_STATUS, 16'h0001);
    chk(irq, 16'h0000);
    @(posedge sys_clk) {start, burst} <= {1'b1, 17'h00003};
    @(posedge sys_clk) start <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd(`OFF_RX_ERR_COUNT, 16'h0003);
    @(posedge sys_clk) {start, burst} <= {1'b1, 17'h10000};
    @(posedge sys_clk) start <= 1'b0;
    repeat (65540) @(posedge sys_clk);
    wr(`OFF_RX_ERR_COUNT, 16'h0000);
    rd(`OFF_RX_ERR_COUNT, 16'hFFFF);
    tally_and_finish;
  end
endmodule // copper_phy_control_regs_bench
